/* verilog/sio_disk_attach.sv */
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module sio_disk_attach (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  output logic op_start,
  output logic [3:0] op_drive,
  output logic [3:0] op_code,
  input wire logic [3:0] seek_done,
  input wire logic op_done,
  // interrupt
  output logic irq
);

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_err;
  logic [31:0] rd_data;

  logic [23:0] cmd_q;
  logic [23:0] cmd_d;
  logic [5:0] irq_stat_q;
  logic [5:0] irq_mask_q;
  logic cfg_q;
  logic int_en_q;
  logic rejected_q;
  logic unaddr_q;
  sio_pkg::att_state_t state_q;
  sio_pkg::op_t op_q;
  logic [3:0] drive_q;
  logic op_start_q;
  logic irq_q;

  logic dec_addressed;
  logic [3:0] dec_drive;
  logic dec_op_valid;
  sio_pkg::op_t dec_op;
  logic dec_ictl_valid;
  logic dec_ictl_enable;
  logic [3:0] dec_seek_rst;
  logic dec_opend_rst;
  logic dec_ictl_disable;
  logic dec_unassigned;

  logic cmd_wr;
  logic take_op;
  logic take_hang;
  logic take_ictl;
  logic stat_w1c;
  logic irq_w1c;

  function automatic logic mapped(input logic [7:0] a);
    if (a == sio_pkg::ADDR_CMD) begin
      mapped = 1'b1;
    end else if (a == sio_pkg::ADDR_STATUS) begin
      mapped = 1'b1;
    end else if (a == sio_pkg::ADDR_IRQ_STAT) begin
      mapped = 1'b1;
    end else if (a == sio_pkg::ADDR_IRQ_MASK) begin
      mapped = 1'b1;
    end else if (a == sio_pkg::ADDR_CONFIG) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction

  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = {8'h00, old};
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r[23:0];
  endfunction

  sio_axil_slave u_bus (
    .ref_clk(ref_clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = !mapped(wr_addr);
  assign rd_err = !mapped(s_axi_araddr);

  // command word laid out with field positions
  assign cmd_d = merge(cmd_q, wr_data, wr_strb);

  sio_cmd_decode u_dec (
    .cmd(cmd_d),
    .intctl_present(cfg_q),
    .addressed(dec_addressed),
    .drive_sel(dec_drive),
    .op_valid(dec_op_valid),
    .op(dec_op),
    .ictl_valid(dec_ictl_valid),
    .ictl_enable(dec_ictl_enable),
    .ictl_seek_rst(dec_seek_rst),
    .ictl_opend_rst(dec_opend_rst),
    .ictl_disable(dec_ictl_disable),
    .unassigned(dec_unassigned)
  );

  assign cmd_wr = wr_en && (wr_addr == sio_pkg::ADDR_CMD);
  assign stat_w1c = wr_en && (wr_addr == sio_pkg::ADDR_STATUS);
  assign irq_w1c = wr_en && (wr_addr == sio_pkg::ADDR_IRQ_STAT);
  // a hung attachment takes no operation, interrupt-control or hang command until reset
  assign take_op = cmd_wr && dec_addressed && dec_op_valid && (state_q == sio_pkg::ST_IDLE);
  assign take_ictl = cmd_wr && dec_addressed && dec_ictl_valid && (state_q != sio_pkg::ST_HUNG);
  assign take_hang = cmd_wr && dec_unassigned && (state_q != sio_pkg::ST_HUNG);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_q <= 24'h000000;
    end else if (cmd_wr) begin
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= sio_pkg::ST_IDLE;
    end else begin
      case (state_q)
        sio_pkg::ST_IDLE: begin
          if (take_hang) begin
            state_q <= sio_pkg::ST_HUNG;
          end else if (take_op) begin
            state_q <= sio_pkg::ST_BUSY;
          end
        end
        sio_pkg::ST_BUSY: begin
          if (take_hang) begin
            state_q <= sio_pkg::ST_HUNG;
          end else if (op_done) begin
            state_q <= sio_pkg::ST_IDLE;
          end
        end
        sio_pkg::ST_HUNG: begin
          state_q <= sio_pkg::ST_HUNG;
        end
        default: begin
          state_q <= sio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      op_start_q <= 1'b0;
      op_q <= sio_pkg::OP_SEEK;
      drive_q <= 4'h0;
    end else begin
      op_start_q <= take_op;
      if (take_op) begin
        op_q <= dec_op;
        drive_q <= dec_drive;
      end
    end
  end

  // sticky command flags; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rejected_q <= 1'b0;
      unaddr_q <= 1'b0;
    end else begin
      if (cmd_wr && dec_addressed && dec_op_valid && !take_op) begin
        rejected_q <= 1'b1;
      end else if (stat_w1c && wr_strb[0] && wr_data[sio_pkg::ST_REJECT_BIT]) begin
        rejected_q <= 1'b0;
      end
      if (cmd_wr && !dec_addressed) begin
        unaddr_q <= 1'b1;
      end else if (stat_w1c && wr_strb[0] && wr_data[sio_pkg::ST_UNADDR_BIT]) begin
        unaddr_q <= 1'b0;
      end
    end
  end

  // interrupt enable set and clear; enabling wins if both bits are given
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_en_q <= 1'b0;
    end else if (take_ictl && dec_ictl_enable) begin
      int_en_q <= 1'b1;
    end else if (take_ictl && dec_ictl_disable) begin
      int_en_q <= 1'b0;
    end
  end

  // seek-complete bits reset by command or by write-one
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seek_irq
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          irq_stat_q[sio_pkg::IRQ_SEEK_LSB + g] <= 1'b0;
        end else if (seek_done[g]) begin
          irq_stat_q[sio_pkg::IRQ_SEEK_LSB + g] <= 1'b1;
        end else if ((take_ictl && dec_seek_rst[g]) ||
                     (irq_w1c && wr_strb[0] && wr_data[sio_pkg::IRQ_SEEK_LSB + g])) begin
          irq_stat_q[sio_pkg::IRQ_SEEK_LSB + g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_stat_q[sio_pkg::IRQ_OPEND_BIT] <= 1'b0;
    end else if (op_done && (state_q == sio_pkg::ST_BUSY)) begin
      irq_stat_q[sio_pkg::IRQ_OPEND_BIT] <= 1'b1;
    end else if ((take_ictl && dec_opend_rst) ||
                 (irq_w1c && wr_strb[0] && wr_data[sio_pkg::IRQ_OPEND_BIT])) begin
      irq_stat_q[sio_pkg::IRQ_OPEND_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_stat_q[sio_pkg::IRQ_HANG_BIT] <= 1'b0;
    end else if (take_hang) begin
      irq_stat_q[sio_pkg::IRQ_HANG_BIT] <= 1'b1;
    end else if (irq_w1c && wr_strb[0] && wr_data[sio_pkg::IRQ_HANG_BIT]) begin
      irq_stat_q[sio_pkg::IRQ_HANG_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_mask_q <= sio_pkg::IRQ_MASK_RST;
      cfg_q <= sio_pkg::CONFIG_RST;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == sio_pkg::ADDR_IRQ_MASK) begin
        irq_mask_q <= wr_data[5:0];
      end else if (wr_addr == sio_pkg::ADDR_CONFIG) begin
        cfg_q <= wr_data[0];
      end
    end
  end

  // without the interrupt-control function there is no enable to gate with
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (|(irq_stat_q & irq_mask_q)) && (int_en_q || !cfg_q);
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (s_axi_araddr == sio_pkg::ADDR_CMD) begin
      rd_data[23:0] = cmd_q;
    end else if (s_axi_araddr == sio_pkg::ADDR_STATUS) begin
      rd_data[sio_pkg::ST_STATE_LSB +: 3] = state_q;
      rd_data[sio_pkg::ST_INTEN_BIT] = int_en_q;
      rd_data[sio_pkg::ST_REJECT_BIT] = rejected_q;
      rd_data[sio_pkg::ST_UNADDR_BIT] = unaddr_q;
      rd_data[sio_pkg::ST_DRIVE_LSB +: 4] = drive_q;
      rd_data[sio_pkg::ST_OP_LSB +: 4] = op_q;
    end else if (s_axi_araddr == sio_pkg::ADDR_IRQ_STAT) begin
      rd_data[5:0] = irq_stat_q;
    end else if (s_axi_araddr == sio_pkg::ADDR_IRQ_MASK) begin
      rd_data[5:0] = irq_mask_q;
    end else if (s_axi_araddr == sio_pkg::ADDR_CONFIG) begin
      rd_data[0] = cfg_q;
    end
  end

  assign op_start = op_start_q;
  assign op_drive = drive_q;
  assign op_code = op_q;
  assign irq = irq_q;

endmodule

/* include/sio_pkg.sv */
package sio_pkg;

  // register byte offsets on the lite bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG = 8'h10;

  // command word: bit n of the start command sits at word bit 23-n
  localparam int UNIT_LSB = 12;
  localparam int QUAL_BIT = 11;
  localparam int FUNC_LSB = 8;
  localparam int MOD_LSB = 0;
  localparam int CMD_W = 24;

  localparam logic [3:0] UNIT_PAIR_A = 4'hc;
  localparam logic [3:0] UNIT_PAIR_B = 4'hd;

  localparam logic [2:0] FUNC_CONTROL = 3'h0;
  localparam logic [2:0] FUNC_READ = 3'h1;
  localparam logic [2:0] FUNC_WRITE = 3'h2;
  localparam logic [2:0] FUNC_SCAN = 3'h3;
  localparam logic [2:0] FUNC_INTCTL = 3'h4;

  localparam logic [7:0] MOD_SEEK = 8'h00;
  localparam logic [7:0] MOD_RECAL = 8'h01;
  localparam logic [7:0] MOD_KD = 8'h00;
  localparam logic [7:0] MOD_HA = 8'h01;
  localparam logic [7:0] MOD_CKD = 8'h02;
  localparam logic [7:0] MOD_VKD = 8'h03;
  localparam logic [7:0] MOD_CKD_DIAG = 8'h04;
  localparam logic [7:0] MOD_BUF_DIAG = 8'h07;
  localparam logic [7:0] MOD_SCAN_EQ = 8'h08;
  localparam logic [7:0] MOD_SCAN_LE = 8'h09;
  localparam logic [7:0] MOD_SCAN_HE = 8'h0a;

  // interrupt-control modifier bits
  localparam int ICTL_ENABLE_BIT = 7;
  localparam int ICTL_SEEK1_BIT = 6;
  localparam int ICTL_OPEND_BIT = 2;
  localparam int ICTL_DISABLE_BIT = 1;
  localparam int ICTL_SPARE_BIT = 0;

  // interrupt status / mask layout
  localparam int IRQ_SEEK_LSB = 0;
  localparam int IRQ_OPEND_BIT = 4;
  localparam int IRQ_HANG_BIT = 5;
  localparam int IRQ_W = 6;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;

  // status register layout
  localparam int ST_STATE_LSB = 0;
  localparam int ST_INTEN_BIT = 3;
  localparam int ST_REJECT_BIT = 4;
  localparam int ST_UNADDR_BIT = 5;
  localparam int ST_DRIVE_LSB = 8;
  localparam int ST_OP_LSB = 12;

  // config: interrupt-control function fitted
  localparam logic CONFIG_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_SEEK = 4'h0,
    OP_RECAL = 4'h1,
    OP_READ_KD = 4'h2,
    OP_READ_HA = 4'h3,
    OP_READ_CKD = 4'h4,
    OP_READ_VKD = 4'h5,
    OP_READ_CKD_DIAG = 4'h6,
    OP_READ_BUF_DIAG = 4'h7,
    OP_WRITE_KD = 4'h8,
    OP_WRITE_HA = 4'h9,
    OP_WRITE_CKD = 4'ha,
    OP_SCAN_EQ = 4'hb,
    OP_SCAN_LE = 4'hc,
    OP_SCAN_HE = 4'hd
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_HUNG = 3'b100
  } att_state_t;

endpackage

/* verilog/sio_cmd_decode.sv */
`timescale 1ns/100ps
module sio_cmd_decode (
  // command under decode
  input wire logic [23:0] cmd,
  input wire logic intctl_present,
  // decode results
  output logic addressed,
  output logic [3:0] drive_sel,
  output logic op_valid,
  output sio_pkg::op_t op,
  output logic ictl_valid,
  output logic ictl_enable,
  output logic [3:0] ictl_seek_rst,
  output logic ictl_opend_rst,
  output logic ictl_disable,
  output logic unassigned
);

  logic [3:0] unit;
  logic qual;
  logic [2:0] func;
  logic [7:0] modf;

  assign unit = cmd[sio_pkg::UNIT_LSB +: 4];
  assign qual = cmd[sio_pkg::QUAL_BIT];
  assign func = cmd[sio_pkg::FUNC_LSB +: 3];
  assign modf = cmd[sio_pkg::MOD_LSB +: 8];

  assign addressed = (unit == sio_pkg::UNIT_PAIR_A) || (unit == sio_pkg::UNIT_PAIR_B);
  assign drive_sel = 4'h1 << {unit[0], qual};

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_seek
      assign ictl_seek_rst[i] = ictl_valid & modf[sio_pkg::ICTL_SEEK1_BIT - i];
    end
  endgenerate

  always_comb begin
    op_valid = 1'b0;
    op = sio_pkg::OP_SEEK;
    ictl_valid = 1'b0;
    case (func)
      sio_pkg::FUNC_CONTROL: begin
        op_valid = 1'b1;
        if (modf == sio_pkg::MOD_SEEK) begin
          op = sio_pkg::OP_SEEK;
        end else if (modf == sio_pkg::MOD_RECAL) begin
          op = sio_pkg::OP_RECAL;
        end else begin
          op_valid = 1'b0;
        end
      end
      sio_pkg::FUNC_READ: begin
        op_valid = 1'b1;
        case (modf)
          sio_pkg::MOD_KD: op = sio_pkg::OP_READ_KD;
          sio_pkg::MOD_HA: op = sio_pkg::OP_READ_HA;
          sio_pkg::MOD_CKD: op = sio_pkg::OP_READ_CKD;
          sio_pkg::MOD_VKD: op = sio_pkg::OP_READ_VKD;
          sio_pkg::MOD_CKD_DIAG: op = sio_pkg::OP_READ_CKD_DIAG;
          sio_pkg::MOD_BUF_DIAG: op = sio_pkg::OP_READ_BUF_DIAG;
          default: op_valid = 1'b0;
        endcase
      end
      sio_pkg::FUNC_WRITE: begin
        op_valid = 1'b1;
        case (modf)
          sio_pkg::MOD_KD: op = sio_pkg::OP_WRITE_KD;
          sio_pkg::MOD_HA: op = sio_pkg::OP_WRITE_HA;
          sio_pkg::MOD_CKD: op = sio_pkg::OP_WRITE_CKD;
          default: op_valid = 1'b0;
        endcase
      end
      sio_pkg::FUNC_SCAN: begin
        op_valid = 1'b1;
        case (modf)
          sio_pkg::MOD_SCAN_EQ: op = sio_pkg::OP_SCAN_EQ;
          sio_pkg::MOD_SCAN_LE: op = sio_pkg::OP_SCAN_LE;
          sio_pkg::MOD_SCAN_HE: op = sio_pkg::OP_SCAN_HE;
          default: op_valid = 1'b0;
        endcase
      end
      sio_pkg::FUNC_INTCTL: begin
        ictl_valid = intctl_present && (modf != 8'h00) && !modf[sio_pkg::ICTL_SPARE_BIT];
      end
      default: begin
        op_valid = 1'b0;
      end
    endcase
  end

  assign ictl_enable = ictl_valid & modf[sio_pkg::ICTL_ENABLE_BIT];
  assign ictl_opend_rst = ictl_valid & modf[sio_pkg::ICTL_OPEND_BIT];
  assign ictl_disable = ictl_valid & modf[sio_pkg::ICTL_DISABLE_BIT];

  assign unassigned = addressed & !op_valid & !ictl_valid;

endmodule

/* verilog/sio_axil_slave.sv */
`timescale 1ns/100ps
module sio_axil_slave (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // lite bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic aw_held_q;
  logic w_held_q;

  // address and data may arrive in either order; each is held until both are in
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      wr_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      w_held_q <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_en) begin
      w_held_q <= 1'b0;
    end
  end

  assign wr_en = aw_held_q && w_held_q && !s_axi_bvalid;

  // readies are registered from their next-cycle condition so they leave a flop
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= !wr_en && !aw_held_q && !(s_axi_awvalid && s_axi_awready) &&
                       !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready <= !wr_en && !w_held_q && !(s_axi_wvalid && s_axi_wready) &&
                      !(s_axi_bvalid && !s_axi_bready);
      s_axi_arready <= !(s_axi_arvalid && s_axi_arready) && !(s_axi_rvalid && !s_axi_rready);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sio_pkg::RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? sio_pkg::RESP_SLVERR : sio_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sio_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? sio_pkg::RESP_SLVERR : sio_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* bench/drive_model.sv */
`timescale 1ns/100ps
module drive_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // launch side
  input wire logic op_start,
  input wire logic [3:0] op_drive,
  input wire logic [3:0] op_code,
  input wire logic [7:0] lat,
  // completion side
  output logic [3:0] seek_done,
  output logic op_done
);
  logic [7:0] cnt_q;
  logic [3:0] drv_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 8'h00;
      drv_q <= 4'h0;
      seek_done <= 4'h0;
      op_done <= 1'b0;
    end else begin
      seek_done <= 4'h0;
      op_done <= 1'b0;
      if (op_start) begin
        cnt_q <= lat;
        drv_q <= (op_code < 4'h2) ? op_drive : 4'h0;
      end else if (cnt_q == 8'h01) begin
        seek_done <= drv_q;
        op_done <= 1'b1;
        cnt_q <= 8'h00;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

/* bench/disk_attach_asserts.sv */
`timescale 1ns/100ps
module disk_attach_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus handshakes
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // drive side
  input wire logic op_start,
  input wire logic [3:0] op_drive,
  input wire logic [3:0] op_code,
  input wire logic op_done
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic busy_q;
  logic [2:0] since_w_q;
  // since_w_q saturates so an old write never looks recent
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      since_w_q <= 3'h7;
    end else begin
      busy_q <= op_start || (busy_q && !op_done);
      if (s_axi_wvalid && s_axi_wready) since_w_q <= 3'h0;
      else if (since_w_q != 3'h7) since_w_q <= since_w_q + 3'h1;
    end
  end
  a_launch_pulse: assert property (op_start |=> !op_start)
    else $error("launch pulse longer than one cycle");
  a_drive_onehot: assert property (op_start |-> $onehot(op_drive))
    else $error("launch without a single drive");
  a_drive_held: assert property ($changed(op_drive) |-> op_start)
    else $error("drive select moved without launch");
  a_code_known: assert property (op_start |-> op_code <= 4'hd)
    else $error("launch with unknown operation");
  a_launch_cause: assert property (op_start |-> since_w_q <= 3'h3)
    else $error("launch without a recent command write");
  a_busy_single: assert property (op_start |-> !busy_q)
    else $error("launch while an operation is running");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  c_launch: cover property (op_start);
  c_drive4: cover property (op_start && op_drive == 4'h8);
  c_done: cover property (op_done && busy_q);
endmodule

bind sio_disk_attach disk_attach_asserts u_chk (
  .ref_clk(ref_clk), .reset(reset), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .op_start(op_start),
  .op_drive(op_drive), .op_code(op_code), .op_done(op_done));

/* bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h01;
  logic [31:0] wdata = 32'h0, rd, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, op_start, op_done, irq;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] op_drive, op_code, seek_done, last_drv, last_code;
  int error_cnt = 0, compares = 0, cyc = 0, starts = 0;
  // func and modifier per op code, in code order
  logic [10:0] ops [14] = '{11'h000, 11'h001, 11'h100, 11'h101, 11'h102, 11'h103,
    11'h104, 11'h107, 11'h200, 11'h201, 11'h202, 11'h308, 11'h309, 11'h30a};
  always #2 ref_clk = ~ref_clk;
  sio_disk_attach u_dut (.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .op_start(op_start), .op_drive(op_drive), .op_code(op_code),
    .seek_done(seek_done), .op_done(op_done), .irq(irq));
  drive_model u_drv (.ref_clk(ref_clk), .reset(reset), .op_start(op_start),
    .op_drive(op_drive), .op_code(op_code), .lat(lat), .seek_done(seek_done),
    .op_done(op_done));
  always @(posedge ref_clk) begin
    cyc++;
    if (op_start) begin
      starts++;
      last_drv = op_drive;
      last_code = op_code;
    end
    if (cyc == 20000) begin
      error_cnt++;
      $display("MISMATCH run_time expected finish seen hang");
      complete_run();
    end
  end
  task complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task axr(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d);
    chk("bresp", 32'(sio_pkg::RESP_OKAY), 32'(rs));
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(nm, e, rd & m);
  endtask
  task irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'(e), 32'(irq));
  endtask
  function automatic logic [31:0] cmd(input int d, input logic [2:0] f, input logic [7:0] m);
    logic [3:0] u;
    u = (d < 2) ? sio_pkg::UNIT_PAIR_A : sio_pkg::UNIT_PAIR_B;
    return {16'h0000, u, d[0], f, m};
  endfunction
  task launch(input logic [31:0] c, input int d, input int code);
    int s0;
    int n;
    s0 = starts;
    n = 0;
    wr(sio_pkg::ADDR_CMD, c);
    while (starts == s0 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    chk("op_drive", 32'h1 << d, 32'(last_drv));
    chk("op_code", code, 32'(last_code));
    n = 0;
    rd = 32'h0;
    while (rd[2:0] !== 3'b001 && n < 40) begin
      axr(sio_pkg::ADDR_STATUS);
      n++;
    end
    chk("state", 32'h1, 32'(rd[2:0]));
  endtask
  task t_ops();
    for (int d = 0; d < 4; d++) begin
      for (int i = 0; i < 14; i++) begin
        lat <= i[0] ? 8'h01 : 8'h0c;
        launch(cmd(d, ops[i][10:8], ops[i][7:0]), d, i);
      end
    end
  endtask
  task t_irq();
    wr(sio_pkg::ADDR_IRQ_STAT, 32'h3f);
    wr(sio_pkg::ADDR_IRQ_MASK, 32'h3f);
    wr(sio_pkg::ADDR_CMD, cmd(0, sio_pkg::FUNC_INTCTL, 8'h80));
    for (int d = 0; d < 4; d++) begin
      launch(cmd(d, sio_pkg::FUNC_CONTROL, 8'h00), d, 0);
      rdc("irq_stat", sio_pkg::ADDR_IRQ_STAT, 32'h3f, 32'h10 | (32'h1 << d));
      irq_is(1'b1);
      wr(sio_pkg::ADDR_CMD, cmd(0, sio_pkg::FUNC_INTCTL, (8'h40 >> d) | 8'h04));
      rdc("irq_stat", sio_pkg::ADDR_IRQ_STAT, 32'h3f, 32'h0);
      irq_is(1'b0);
    end
    launch(cmd(1, sio_pkg::FUNC_CONTROL, 8'h01), 1, 1);
    irq_is(1'b1);
    wr(sio_pkg::ADDR_CMD, cmd(0, sio_pkg::FUNC_INTCTL, 8'h02));
    rdc("int_en", sio_pkg::ADDR_STATUS, 32'h8, 32'h0);
    irq_is(1'b0);
    wr(sio_pkg::ADDR_IRQ_STAT, 32'h3f);
    rdc("irq_stat", sio_pkg::ADDR_IRQ_STAT, 32'h3f, 32'h0);
    wr(sio_pkg::ADDR_CMD, 32'h0);
    rdc("unaddr", sio_pkg::ADDR_STATUS, 32'h20, 32'h20);
    axr(8'h40);
    chk("rresp", 32'(sio_pkg::RESP_SLVERR), 32'(rs));
    chk("rdata", 32'h0, rd);
    axw(8'h40, 32'hffffffff);
    chk("bresp", 32'(sio_pkg::RESP_SLVERR), 32'(rs));
  endtask
  task rst();
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  task t_hang();
    logic [31:0] hc [4];
    hc = '{cmd(0, sio_pkg::FUNC_INTCTL, 8'h80), cmd(3, sio_pkg::FUNC_READ, 8'h05),
      cmd(1, sio_pkg::FUNC_CONTROL, 8'h02), cmd(2, 3'h7, 8'h00)};
    wr(sio_pkg::ADDR_CONFIG, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(sio_pkg::ADDR_CMD, hc[i]);
      rdc("hung", sio_pkg::ADDR_STATUS, 32'h7, 32'h4);
      rdc("hang_flag", sio_pkg::ADDR_IRQ_STAT, 32'h20, 32'h20);
      rst();
    end
    rdc("config", sio_pkg::ADDR_CONFIG, 32'h1, 32'h1);
    rdc("mask", sio_pkg::ADDR_IRQ_MASK, 32'h3f, 32'h0);
  endtask
  initial begin
    rst();
    t_ops();
    t_irq();
    t_hang();
    complete_run();
  end
endmodule
